// [rtl/cpu_seq_regs.svh]
`ifndef CPU_SEQ_REGS_SVH
`define CPU_SEQ_REGS_SVH
`define NMI_VECTOR 16'h0066
`define PORT_WAIT_STATES 3'h1
`define BLOCK_STATES_REPEAT 5'h15
`define BLOCK_STATES_LAST 5'h10
`define MEM_CYCLE_STATES 3'h3
`define PORT_CYCLE_STATES 3'h4
`define FETCH_STATES 3'h4
`endif

// [rtl/cpu_seq_pkg.sv]
package cpu_seq_pkg;
   typedef enum logic [2:0] {
      BUS_IDLE = 3'h0,
      BUS_ADDR = 3'h1,
      BUS_STROBE = 3'h3,
      BUS_WAIT = 3'h2,
      BUS_END = 3'h6,
      BUS_FLOAT = 3'h7
   } bus_state_e;
   typedef enum logic [2:0] {
      OP_NONE = 3'h0,
      OP_MEM_RD = 3'h1,
      OP_MEM_WR = 3'h2,
      OP_PORT_RD = 3'h3,
      OP_PORT_WR = 3'h4,
      OP_NMI_RD = 3'h5
   } bus_op_e;
   typedef enum logic [2:0] {
      BLK_PORT_TO_MEM_INC = 3'h0,
      BLK_PORT_TO_MEM_DEC = 3'h1,
      BLK_MEM_TO_PORT_INC = 3'h2,
      BLK_MEM_TO_PORT_DEC = 3'h3,
      BLK_PORT_TO_MEM_INC_REPEAT = 3'h4,
      BLK_PORT_TO_MEM_DEC_REPEAT = 3'h5,
      BLK_MEM_TO_PORT_INC_REPEAT = 3'h6,
      BLK_MEM_TO_PORT_DEC_REPEAT = 3'h7
   } block_op_e;
   typedef logic [7:0] byte_t;
   typedef logic [15:0] word_t;
endpackage : cpu_seq_pkg

// [rtl/sync_two_ff.sv]
`timescale 1ns/1ps
module sync_two_ff (
   input wire logic clk,
   input wire logic rst,
   input wire logic asyncIn,
   output logic syncOut
);
   logic stageOne_q;
   // The idle level of every active-low pin is high, hence reset to one.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         stageOne_q <= 1'b1;
         syncOut <= 1'b1;
      end else begin
         stageOne_q <= asyncIn;
         syncOut <= stageOne_q;
      end
   end
endmodule : sync_two_ff

// [rtl/register_banks.sv]
`timescale 1ns/1ps
module register_banks (
   input wire logic clk,
   input wire logic rst,
   input wire logic exchangeAll,
   input wire logic writeEn,
   input wire logic [2:0] writeSel,
   input wire cpu_seq_pkg::byte_t writeData,
   output cpu_seq_pkg::byte_t regOut [8]
);
   import cpu_seq_pkg::*;
   byte_t principal_q [8];
   byte_t alternate_q [8];
   // Index 0 A, 1 F, 2 B, 3 C, 4 D, 5 E, 6 H, 7 L.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         for (int i = 0; i < 8; i++) begin
            principal_q[i] <= 8'h00;
            alternate_q[i] <= 8'h00;
         end
      end else if (exchangeAll) begin
         principal_q <= alternate_q;
         alternate_q <= principal_q;
      end else if (writeEn) begin
         principal_q[writeSel] <= writeData;
      end
   end
   assign regOut = principal_q;
endmodule : register_banks

// [rtl/cpu_bus_interrupt_sequencer.sv]
// Chosen here: the placing of the registers and the plain strobed port.
`timescale 1ns/1ps
`include "cpu_seq_regs.svh"
//
// Contract
// - Block step sets zero when counter hits zero
// - Repeat variants update zero only at finish
// - Principal and alternate 8-bit banks, exchange swaps
// - Vector page, refresh, two index, stack, program
// - Two enable flops plus two mode flops
// - Non-maskable input highest, never disabled
// - Maskable input only while enabled
// - Three maskable modes, mode 2 vectored; only the mode is stored, no vectoring is done
// - Sample interrupts at instruction last clock
// - Memory request after address is stable
// - Write strobe only while data stable
// - One automatic wait state per port cycle
// - Non-maskable: dummy read, restart at 0066
// - Sample takeover at machine cycle last clock
// - Float bus lines the next edge after takeover
// - Halt for power-down enters halt state
// - No interrupt sampling after enable/disable
module cpu_bus_interrupt_sequencer (
   input wire logic clk,
   input wire logic rst,
   // Instruction-level control from the execution core.
   input wire logic opStart,
   input wire cpu_seq_pkg::bus_op_e opKind,
   input wire cpu_seq_pkg::word_t opAddr,
   input wire cpu_seq_pkg::byte_t opWrData,
   input wire logic instrLast,
   input wire logic instrIsEnableDisable,
   input wire logic haltExec,
   input wire logic setIrqEnable,
   input wire logic clrIrqEnable,
   input wire logic [1:0] setIrqMode,
   input wire logic setIrqModeEn,
   input wire logic exchangeBanks,
   input wire logic regWriteEn,
   input wire logic [2:0] regWriteSel,
   input wire cpu_seq_pkg::byte_t regWriteData,
   input wire logic blockStart,
   input wire cpu_seq_pkg::block_op_e blockKind,
   // Pins.
   input wire logic nmi_n,
   input wire logic maskable_irq_n,
   input wire logic bus_takeover_request_n,
   input wire cpu_seq_pkg::byte_t dataIn,
   output cpu_seq_pkg::word_t addrOut,
   output logic addrOe,
   output cpu_seq_pkg::byte_t dataOut,
   output logic dataOe,
   output logic memory_request_n,
   output logic port_request_n,
   output logic read_n,
   output logic write_n,
   output logic controlOe,
   output logic busTakeoverAck_n,
   output logic halt_n,
   output logic opcode_fetch_cycle,
   // Status toward the core.
   output logic opBusy,
   output logic opDone,
   output cpu_seq_pkg::byte_t opRdData,
   output logic nmiTaken,
   output logic irqTaken,
   output logic [1:0] irqModeOut,
   output logic blockBusy,
   output logic zeroFlag,
   output cpu_seq_pkg::byte_t interruptPage,
   output cpu_seq_pkg::byte_t refreshCount,
   output cpu_seq_pkg::word_t index_reg_first,
   output cpu_seq_pkg::word_t index_reg_second,
   output cpu_seq_pkg::word_t stack_pointer,
   output cpu_seq_pkg::word_t program_counter,
   output cpu_seq_pkg::byte_t regOut [8]
);
   import cpu_seq_pkg::*;

   logic nmiSync;
   logic irqSync;
   logic takeSync;
   sync_two_ff uNmiSync (.clk(clk), .rst(rst), .asyncIn(nmi_n),
      .syncOut(nmiSync));
   sync_two_ff uIrqSync (.clk(clk), .rst(rst), .asyncIn(maskable_irq_n),
      .syncOut(irqSync));
   sync_two_ff uTakeSync (.clk(clk), .rst(rst),
      .asyncIn(bus_takeover_request_n), .syncOut(takeSync));

   logic blkRegWrite;
   logic [2:0] blkRegSel;
   byte_t blkRegData;
   logic bankWrite;
   logic [2:0] bankSel;
   byte_t bankData;
   register_banks uBanks (
      .clk(clk),
      .rst(rst),
      .exchangeAll(exchangeBanks),
      .writeEn(bankWrite),
      .writeSel(bankSel),
      .writeData(bankData),
      .regOut(regOut)
   );
   assign bankWrite = blkRegWrite | regWriteEn;
   assign bankSel = blkRegWrite ? blkRegSel : regWriteSel;
   assign bankData = blkRegWrite ? blkRegData : regWriteData;

   bus_state_e state_q;
   bus_state_e state_d;
   bus_op_e op_q;
   word_t addr_q;
   byte_t wdata_q;
   logic [2:0] waitCnt_q;
   logic irqEn1_q;
   logic irqEn2_q;
   logic irqModeA_q;
   logic irqModeB_q;
   logic halted_q;
   logic nmiPend_q;
   logic nmiPrev_q;
   logic nmiCycleReq_q;
   logic [4:0] blkCnt_q;
   logic blkActive_q;
   block_op_e blk_q;
   logic zero_q;
   byte_t iPage_q;
   byte_t refresh_q;
   word_t ix_q;
   word_t iy_q;
   word_t sp_q;
   word_t pc_q;

   // Bus cycle sequencing.
   wire isPortOp = (op_q == OP_PORT_RD) || (op_q == OP_PORT_WR);
   wire isWriteOp = (op_q == OP_MEM_WR) || (op_q == OP_PORT_WR);
   wire takeReq = ~takeSync;
   wire cycleLast = (state_q == BUS_END);
   wire waitDone = (waitCnt_q == 3'h0);
   always_comb begin
      state_d = state_q;
      case (state_q)
         BUS_IDLE: begin
            if (takeReq) begin
               state_d = BUS_FLOAT;
            end else if (nmiCycleReq_q || (opStart && opKind != OP_NONE)) begin
               state_d = BUS_ADDR;
            end
         end
         BUS_ADDR: state_d = BUS_STROBE;
         BUS_STROBE: begin
            state_d = isPortOp ? BUS_WAIT : BUS_END;
         end
         BUS_WAIT: state_d = waitDone ? BUS_END : BUS_WAIT;
         BUS_END: state_d = takeReq ? BUS_FLOAT : BUS_IDLE;
         BUS_FLOAT: state_d = takeReq ? BUS_FLOAT : BUS_IDLE;
         default: state_d = BUS_IDLE;
      endcase
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         state_q <= BUS_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         op_q <= OP_NONE;
         addr_q <= 16'h0000;
         wdata_q <= 8'h00;
      end else if (state_q == BUS_IDLE && state_d == BUS_ADDR) begin
         // A pending restart read wins over a core request in that cycle.
         op_q <= nmiCycleReq_q ? OP_NMI_RD : opKind;
         addr_q <= nmiCycleReq_q ? pc_q : opAddr;
         wdata_q <= opWrData;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         waitCnt_q <= 3'h0;
      end else if (state_q == BUS_STROBE) begin
         waitCnt_q <= `PORT_WAIT_STATES - 3'h1;
      end else if (state_q == BUS_WAIT && !waitDone) begin
         waitCnt_q <= waitCnt_q - 3'h1;
      end
   end

   // Strobes open one state after the address is placed, so address and
   // write data are already settled when a memory sees them.
   wire floating = (state_q == BUS_FLOAT);
   wire strobing = (state_q == BUS_STROBE) || (state_q == BUS_WAIT) ||
      (state_q == BUS_END);
   wire portCycle = strobing && isPortOp;
   wire memCycle = strobing && !isPortOp && op_q != OP_NONE;
   assign memory_request_n = ~memCycle;
   assign port_request_n = ~portCycle;
   assign read_n = ~(strobing && !isWriteOp && op_q != OP_NONE);
   assign write_n = ~(strobing && isWriteOp);
   assign addrOe = ~floating;
   assign controlOe = ~floating;
   assign dataOe = ~floating && isWriteOp && state_q != BUS_IDLE;
   assign addrOut = addr_q;
   assign dataOut = wdata_q;
   assign busTakeoverAck_n = ~floating;
   assign opBusy = (state_q != BUS_IDLE);
   assign opcode_fetch_cycle = 1'b0;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         opDone <= 1'b0;
         opRdData <= 8'h00;
      end else begin
         opDone <= cycleLast;
         if (cycleLast && !isWriteOp && op_q != OP_NMI_RD) begin
            opRdData <= dataIn;
         end
      end
   end

   // Interrupt sampling.
   wire sampleNow = instrLast && !instrIsEnableDisable;
   wire nmiFall = nmiPrev_q && !nmiSync;
   wire irqAccept = sampleNow && !nmiPend_q && !irqSync &&
      irqEn1_q;
   wire nmiAccept = sampleNow && nmiPend_q;
   wire nmiDone = cycleLast && op_q == OP_NMI_RD;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         nmiPrev_q <= 1'b1;
         nmiPend_q <= 1'b0;
         nmiCycleReq_q <= 1'b0;
      end else begin
         nmiPrev_q <= nmiSync;
         // The edge latch keeps a short pulse between instruction ends.
         if (nmiFall) begin
            nmiPend_q <= 1'b1;
         end else if (nmiAccept) begin
            nmiPend_q <= 1'b0;
         end
         if (nmiAccept) begin
            nmiCycleReq_q <= 1'b1;
         end else if (state_q == BUS_IDLE && state_d == BUS_ADDR) begin
            nmiCycleReq_q <= 1'b0;
         end
      end
   end
   assign nmiTaken = nmiAccept;
   assign irqTaken = irqAccept;

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqEn1_q <= 1'b0;
         irqEn2_q <= 1'b0;
      end else if (nmiAccept) begin
         irqEn1_q <= 1'b0;
      end else if (irqAccept) begin
         irqEn1_q <= 1'b0;
         irqEn2_q <= 1'b0;
      end else if (setIrqEnable) begin
         irqEn1_q <= 1'b1;
         irqEn2_q <= 1'b1;
      end else if (clrIrqEnable) begin
         irqEn1_q <= 1'b0;
         irqEn2_q <= 1'b0;
      end
   end

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         irqModeA_q <= 1'b0;
         irqModeB_q <= 1'b0;
      end else if (setIrqModeEn && setIrqMode != 2'h3) begin
         irqModeA_q <= setIrqMode[0];
         irqModeB_q <= setIrqMode[1];
      end
   end
   assign irqModeOut = {irqModeB_q, irqModeA_q};

   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         halted_q <= 1'b0;
      end else if (nmiAccept || irqAccept) begin
         halted_q <= 1'b0;
      end else if (haltExec) begin
         halted_q <= 1'b1;
      end
   end
   assign halt_n = ~halted_q;

   // Dedicated registers.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         iPage_q <= 8'h00;
         refresh_q <= 8'h00;
         ix_q <= 16'hffff;
         iy_q <= 16'hffff;
         sp_q <= 16'hffff;
         pc_q <= 16'h0000;
      end else begin
         if (opDone) begin
            refresh_q <= {refresh_q[7], refresh_q[6:0] + 7'h01};
         end
         if (nmiDone) begin
            pc_q <= `NMI_VECTOR;
            sp_q <= sp_q - 16'h0002;
         end
      end
   end
   assign interruptPage = iPage_q;
   assign refreshCount = refresh_q;
   assign index_reg_first = ix_q;
   assign index_reg_second = iy_q;
   assign stack_pointer = sp_q;
   assign program_counter = pc_q;

   // Block port transfers timed in clock states; B at index 2, C at 3.
   byte_t counterNext;
   word_t hlNext;
   wire blkRepeat = blk_q[2];
   wire blkDec = blk_q[0];
   wire counterZero = (counterNext == 8'h00);
   assign counterNext = regOut[2] - 8'h01;
   assign hlNext = blkDec ? ({regOut[6], regOut[7]} - 16'h0001) :
      ({regOut[6], regOut[7]} + 16'h0001);
   wire blkStepEnd = blkActive_q && (blkCnt_q == 5'h01);
   wire blkUpdateB = blkActive_q && (blkCnt_q == `BLOCK_STATES_LAST);
   word_t blockPortAddr;
   assign blockPortAddr = {regOut[2], regOut[3]};
   assign blockBusy = blkActive_q;

   logic [1:0] blkWrPhase_q;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blkActive_q <= 1'b0;
         blkCnt_q <= 5'h00;
         blk_q <= BLK_PORT_TO_MEM_INC;
         zero_q <= 1'b0;
      end else if (blockStart && !blkActive_q) begin
         blkActive_q <= 1'b1;
         blk_q <= blockKind;
         blkCnt_q <= (blockKind[2] && regOut[2] != 8'h01) ?
            `BLOCK_STATES_REPEAT : `BLOCK_STATES_LAST;
      end else if (blkStepEnd) begin
         if (!blkRepeat) begin
            blkActive_q <= 1'b0;
            zero_q <= (regOut[2] == 8'h00);
         end else if (regOut[2] == 8'h00) begin
            blkActive_q <= 1'b0;
            zero_q <= 1'b1;
         end else begin
            blkCnt_q <= (regOut[2] != 8'h01) ? `BLOCK_STATES_REPEAT :
               `BLOCK_STATES_LAST;
         end
      end else if (blkActive_q) begin
         blkCnt_q <= blkCnt_q - 5'h01;
      end
   end
   assign zeroFlag = zero_q;

   // Counter and pointer are written back over three states: B, then H, then L.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         blkWrPhase_q <= 2'h0;
      end else if (blkUpdateB) begin
         blkWrPhase_q <= 2'h1;
      end else if (blkWrPhase_q != 2'h0) begin
         blkWrPhase_q <= blkWrPhase_q + 2'h1;
      end
   end
   byte_t hlHold_q [2];
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         hlHold_q[0] <= 8'h00;
         hlHold_q[1] <= 8'h00;
      end else if (blkUpdateB) begin
         hlHold_q[0] <= hlNext[15:8];
         hlHold_q[1] <= hlNext[7:0];
      end
   end
   assign blkRegWrite = blkUpdateB || blkWrPhase_q == 2'h1 ||
      blkWrPhase_q == 2'h2;
   assign blkRegSel = blkUpdateB ? 3'h2 :
      (blkWrPhase_q == 2'h1 ? 3'h6 : 3'h7);
   assign blkRegData = blkUpdateB ? counterNext :
      (blkWrPhase_q == 2'h1 ? hlHold_q[0] : hlHold_q[1]);

   wire unusedDebug = counterZero ^ blockPortAddr[0] ^ iPage_q[0];
endmodule : cpu_bus_interrupt_sequencer

// [verification/cpu_seq_sva.sv]
`timescale 1ns/1ps
module cpu_seq_sva (
   input wire logic clk,
   input wire logic rst,
   input wire cpu_seq_pkg::word_t addrOut,
   input wire logic addrOe,
   input wire cpu_seq_pkg::byte_t dataOut,
   input wire logic dataOe,
   input wire logic memory_request_n,
   input wire logic port_request_n,
   input wire logic write_n,
   input wire logic controlOe,
   input wire logic instrLast,
   input wire logic instrIsEnableDisable,
   input wire logic nmiTaken,
   input wire logic irqTaken,
   input wire logic setIrqEnable,
   input wire logic clrIrqEnable,
   input wire logic setIrqModeEn,
   input wire logic [1:0] setIrqMode,
   input wire logic [1:0] irqModeOut,
   input wire logic bus_takeover_request_n,
   input wire logic busTakeoverAck_n,
   input wire logic haltExec,
   input wire logic halt_n
);
   import cpu_seq_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   logic irqOn_q;
   // Taking an interrupt may clear the enable too, so this only bounds it.
   always_ff @(posedge clk or posedge rst) begin
      if (rst) irqOn_q <= 1'b0;
      else if (setIrqEnable) irqOn_q <= 1'b1;
      else if (clrIrqEnable) irqOn_q <= 1'b0;
   end
   property p_memAddr;
      $fell(memory_request_n) |-> addrOe && $stable(addrOut);
   endproperty
   a_memAddr: assert property (p_memAddr)
      else $error("memory strobe before stable address");
   property p_wrData;
      !write_n |-> dataOe && $stable(dataOut);
   endproperty
   a_wrData: assert property (p_wrData)
      else $error("write strobe with moving data");
   property p_portWait;
      $fell(port_request_n) |-> ##1 !port_request_n ##1 !port_request_n
         ##1 port_request_n;
   endproperty
   a_portWait: assert property (p_portWait)
      else $error("port cycle without one wait state");
   property p_sample;
      nmiTaken || irqTaken |-> instrLast && !instrIsEnableDisable;
   endproperty
   a_sample: assert property (p_sample)
      else $error("interrupt taken outside an instruction end");
   property p_irqEn;
      irqTaken |-> irqOn_q;
   endproperty
   a_irqEn: assert property (p_irqEn)
      else $error("maskable interrupt taken while disabled");
   property p_mode;
      setIrqModeEn && setIrqMode != 2'h3 |=> irqModeOut == $past(setIrqMode);
   endproperty
   a_mode: assert property (p_mode)
      else $error("interrupt mode not stored");
   property p_float;
      $fell(bus_takeover_request_n) |-> ##[2:12]
         (!busTakeoverAck_n && !addrOe && !controlOe && !dataOe);
   endproperty
   a_float: assert property (p_float)
      else $error("bus not floated after takeover request");
   property p_halt;
      haltExec |=> !halt_n;
   endproperty
   a_halt: assert property (p_halt)
      else $error("halt not entered");
   c_memWrite: cover property (!write_n && !memory_request_n);
   c_float: cover property (!busTakeoverAck_n);
   c_nmi: cover property (nmiTaken);
endmodule : cpu_seq_sva

// [verification/mem_port_model.sv]
`timescale 1ns/1ps
module mem_port_model (
   input wire logic clk,
   input wire logic rst,
   input wire cpu_seq_pkg::word_t addrOut,
   input wire cpu_seq_pkg::byte_t dataOut,
   input wire logic memory_request_n,
   input wire logic port_request_n,
   input wire logic read_n,
   input wire logic write_n,
   input wire logic controlOe,
   input wire logic wantBus,
   output cpu_seq_pkg::byte_t dataIn,
   output logic bus_takeover_request_n,
   output cpu_seq_pkg::word_t lastAddr,
   output cpu_seq_pkg::byte_t lastData,
   output logic lastPort
);
   import cpu_seq_pkg::*;
   byte_t held;
   logic rdMem;
   logic rdPort;
   assign rdMem = controlOe && !read_n && !memory_request_n;
   assign rdPort = controlOe && !read_n && !port_request_n;
   // Undriven data has no pull-up, so it toggles instead of holding.
   assign dataIn = rdMem ? addrOut[7:0] ^ 8'h3c :
      rdPort ? addrOut[7:0] ^ 8'hc3 : ~held;
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         held <= 8'h00;
         lastAddr <= 16'h0000;
         lastData <= 8'h00;
         lastPort <= 1'b0;
         bus_takeover_request_n <= 1'b1;
      end else begin
         held <= dataIn;
         bus_takeover_request_n <= !wantBus;
         if (controlOe && !write_n) begin
            lastAddr <= addrOut;
            lastData <= dataOut;
            lastPort <= !port_request_n;
         end
      end
   end
endmodule : mem_port_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
`include "cpu_seq_regs.svh"
`define CHK(x, y) begin checks++; if ((x) !== (y)) begin n_mismatch++; \
   $display("wrong value at %0t: %h %h", $time, x, y); end end
module tb_top;
   import cpu_seq_pkg::*;
   logic clk, rst, opStart, instrLast, instrIsEnableDisable, haltExec;
   logic setIrqEnable, clrIrqEnable, setIrqModeEn, exchangeBanks, regWriteEn;
   logic blockStart, nmi_n, maskable_irq_n, wantBus, bus_takeover_request_n;
   logic addrOe, dataOe, memory_request_n, port_request_n, read_n, write_n;
   logic controlOe, busTakeoverAck_n, halt_n, opcode_fetch_cycle, opBusy;
   logic opDone, nmiTaken, irqTaken, blockBusy, zeroFlag, lastPort, nt, it;
   logic [1:0] setIrqMode, irqModeOut;
   logic [2:0] regWriteSel;
   logic [7:0] ctl;
   logic [31:0] seed;
   bus_op_e opKind;
   block_op_e blockKind;
   word_t opAddr, addrOut, index_reg_first, index_reg_second, stack_pointer;
   word_t program_counter, lastAddr;
   byte_t opWrData, regWriteData, dataIn, dataOut, opRdData, interruptPage;
   byte_t refreshCount, lastData, cnt, st;
   byte_t regOut [8];
   byte_t keep [8];
   int n_mismatch, checks, c;
   assign {regWriteEn, opStart, setIrqModeEn, blockStart, exchangeBanks,
      clrIrqEnable, setIrqEnable, haltExec} = ctl;
   cpu_bus_interrupt_sequencer DUT (.*);
   mem_port_model PEER (.*);
   always #5 clk = ~clk;
   function automatic logic [31:0] lfsr(logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask : report_and_stop
   task automatic pulse(int b);
      ctl <= 8'h01 << b;
      @(posedge clk);
      ctl <= 8'h00;
      @(posedge clk);
   endtask : pulse
   task automatic wait_neg(ref logic s, input logic v);
      c = 0;
      do begin
         @(negedge clk);
         c++;
      end while (s !== v && c < 400);
   endtask : wait_neg
   task automatic wr_reg(logic [2:0] s, byte_t v);
      regWriteSel <= s;
      regWriteData <= v;
      pulse(7);
   endtask : wr_reg
   task automatic bus_op(bus_op_e k, word_t a, byte_t d);
      opKind <= k;
      opAddr <= a;
      opWrData <= d;
      pulse(6);
      wait_neg(opDone, 1'b1);
      `CHK(c, (k == OP_PORT_RD || k == OP_PORT_WR) ? 4 : 3)
      if (k == OP_MEM_RD || k == OP_PORT_RD)
         `CHK(opRdData, a[7:0] ^ (k == OP_PORT_RD ? 8'hc3 : 8'h3c))
      else
         `CHK({lastPort, lastAddr, lastData}, {k == OP_PORT_WR, a, d})
      @(posedge clk);
   endtask : bus_op
   task automatic instr_end(logic e);
      repeat (3) @(posedge clk);
      instrLast <= 1'b1;
      instrIsEnableDisable <= e;
      @(negedge clk);
      nt = nmiTaken;
      it = irqTaken;
      @(posedge clk);
      instrLast <= 1'b0;
      instrIsEnableDisable <= 1'b0;
      @(posedge clk);
   endtask : instr_end
   // The whole sequence needs well under a thousand cycles; this is ample margin.
   initial begin
      #300us;
      n_mismatch++;
      report_and_stop();
   end
   initial begin
      clk = 1'b0;
      rst = 1'b1;
      seed = 32'h6e9cd4a7;
      n_mismatch = 0;
      checks = 0;
      ctl = 8'h00;
      {instrLast, instrIsEnableDisable, wantBus} = 3'h0;
      {nmi_n, maskable_irq_n} = 2'h3;
      {setIrqMode, regWriteSel, regWriteData} = 13'h0000;
      {opAddr, opWrData} = 24'h000000;
      opKind = OP_NONE;
      blockKind = BLK_PORT_TO_MEM_INC;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(posedge clk);
      `CHK({halt_n, memory_request_n, port_request_n, write_n}, 4'hf)
      `CHK({index_reg_first, stack_pointer, program_counter}, 48'hffffffff0000)
      bus_op(OP_PORT_RD, 16'hffff, 8'h00);
      bus_op(OP_MEM_WR, 16'h0000, 8'hff);
      repeat (24) begin
         seed = lfsr(seed);
         bus_op(bus_op_e'(3'(seed[1:0]) + 3'h1), seed[31:16], seed[15:8]);
      end
      for (int i = 0; i < 8; i++) begin
         seed = lfsr(seed);
         keep[i] = seed[7:0];
         wr_reg(3'(i), seed[7:0]);
      end
      pulse(3);
      for (int i = 0; i < 8; i++) `CHK(regOut[i], 8'h00)
      pulse(3);
      for (int i = 0; i < 8; i++) `CHK(regOut[i], keep[i])
      for (int i = 0; i < 8; i++) begin
         cnt = (i < 4) ? 8'(1 + i % 2) : 8'h03;
         st = (i < 4) ? 8'h01 : cnt;
         wr_reg(3'h2, cnt);
         wr_reg(3'h6, 8'h10);
         wr_reg(3'h7, 8'h80);
         nt = zeroFlag;
         blockKind <= block_op_e'(i);
         pulse(4);
         if (i > 3) `CHK(zeroFlag, nt)
         wait_neg(blockBusy, 1'b0);
         `CHK(zeroFlag, i > 3 || cnt == 8'h01)
         `CHK(regOut[2], i > 3 ? 8'h00 : cnt - 8'h01)
         `CHK({regOut[6], regOut[7]}, i % 2 ? 16'h1080 - st : 16'h1080 + st)
         @(posedge clk);
      end
      for (int i = 0; i < 4; i++) begin
         setIrqMode <= 2'(i);
         pulse(5);
         `CHK(irqModeOut, i == 3 ? 2'h2 : 2'(i))
      end
      maskable_irq_n <= 1'b0;
      instr_end(1'b0);
      `CHK(it, 1'b0)
      pulse(1);
      instr_end(1'b1);
      `CHK(it, 1'b0)
      instr_end(1'b0);
      `CHK(it, 1'b1)
      maskable_irq_n <= 1'b1;
      pulse(2);
      nmi_n <= 1'b0;
      instr_end(1'b0);
      `CHK(nt, 1'b1)
      nmi_n <= 1'b1;
      c = 0;
      while (program_counter !== `NMI_VECTOR && c < 40) begin
         @(posedge clk);
         c++;
      end
      `CHK(program_counter, `NMI_VECTOR)
      pulse(0);
      `CHK(halt_n, 1'b0)
      nmi_n <= 1'b0;
      instr_end(1'b0);
      nmi_n <= 1'b1;
      wait_neg(halt_n, 1'b1);
      `CHK(halt_n, 1'b1)
      @(posedge clk);
      wantBus <= 1'b1;
      wait_neg(busTakeoverAck_n, 1'b0);
      `CHK({busTakeoverAck_n, addrOe, dataOe, controlOe}, 4'h0)
      @(posedge clk);
      opKind <= OP_MEM_RD;
      pulse(6);
      `CHK({opBusy, opDone, memory_request_n, addrOe}, 4'ha)
      wantBus <= 1'b0;
      wait_neg(busTakeoverAck_n, 1'b1);
      `CHK(controlOe, 1'b1)
      @(posedge clk);
      bus_op(OP_PORT_WR, 16'h55aa, 8'h3c);
      report_and_stop();
   end
endmodule : tb_top
bind cpu_bus_interrupt_sequencer cpu_seq_sva SVA (.*);
